// File: hdl/phy_regs_pkg.sv
// Constants, field layout and carrier types for the transceiver's vendor
// management registers (strap override, strap status, expanded control,
// interrupt control/status). Assumes a management-frame engine that
// presents one decoded register access per request on the device clock.
package phy_regs_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int NUM_EVENTS = 8;

    // Register offsets on the management bus
    localparam logic [ADDR_W-1:0] OFF_STRAP_OVERRIDE = 5'h16;
    localparam logic [ADDR_W-1:0] OFF_STRAP_STATUS = 5'h17;
    localparam logic [ADDR_W-1:0] OFF_EXPANDED_CTRL = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_INT_CTRL_STATUS = 5'h1b;

    // Strap override register fields
    localparam int OVR_PME_BIT = 15;
    localparam int OVR_RO_BIT = 10;
    localparam int OVR_REPEATER_BIT = 6;
    localparam int OVR_NAND_TREE_BIT = 5;
    localparam int OVR_RMII_BIT = 1;
    localparam logic [DATA_W-1:0] OVR_RESET = 16'h0002;
    localparam logic [DATA_W-1:0] OVR_WRITE_MASK = 16'hfbff;

    // Strap status register fields
    localparam int STAT_ADDR_LSB = 13;
    localparam int STAT_ADDR_W = 2;
    localparam int STAT_RMII_BIT = 1;
    localparam logic [STAT_ADDR_W-1:0] STRAP_ADDR_ZERO = 2'h0;
    localparam logic [STAT_ADDR_W-1:0] STRAP_ADDR_THREE = 2'h3;

    // Expanded control register fields
    localparam int EXP_ENERGY_DETECT_OFF_BIT = 11;
    localparam logic [DATA_W-1:0] EXP_RESET = 16'h0801;

    // Interrupt control/status: enables high byte, flags low byte
    localparam int INT_EN_LSB = 8;
    localparam int INT_FLAG_LSB = 0;
    localparam logic [NUM_EVENTS-1:0] INT_EN_RESET = 8'h00;
    localparam int EV_LINK_UP = 0;
    localparam int EV_REMOTE_FAULT = 1;
    localparam int EV_LINK_DOWN = 2;
    localparam int EV_PARTNER_ACK = 3;
    localparam int EV_PAR_DET_FAULT = 4;
    localparam int EV_PAGE_RX = 5;
    localparam int EV_RX_ERROR = 6;
    localparam int EV_JABBER = 7;

    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } mgmt_rsp_t;

    typedef struct packed {
        logic [STAT_ADDR_W-1:0] mgmtAddr;
        logic rmii;
        logic pme;
    } strap_t;

    typedef struct packed {
        logic repeaterBackToBackMode;
        logic nandTreeMode;
        logic rmiiMode;
        logic pmeEnable;
        logic energyDetectPowerDownEn;
    } mode_t;

endpackage : phy_regs_pkg

// File: hdl/strap_capture.sv
// Captures the strap pins once, on the first clock edge after reset
// release. Assumes the pins are stable across that edge.
module strap_capture
(
    input wire logic clk, // Device clock
    input wire logic rst, // Async reset, active high
    input wire phy_regs_pkg::strap_t strapPins, // Raw strap levels
    output phy_regs_pkg::strap_t strapLatched, // Held strap values
    output logic strapValid // High once straps captured
);
    import phy_regs_pkg::*;

    strap_t strap_q;
    strap_t strap_d;
    logic valid_q;
    logic valid_d;

    always_comb
    begin
        strap_d = strap_q;
        valid_d = 1'b1;
        if (!valid_q)
        begin
            strap_d = strapPins;
            // Only two addresses exist; any other code folds to three
            if (strapPins.mgmtAddr != STRAP_ADDR_ZERO)
            begin
                strap_d.mgmtAddr = STRAP_ADDR_THREE;
            end
        end
    end

    // Async reset loads constants only; pins are sampled after release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strap_q <= '0;
            valid_q <= 1'b0;
        end
        else
        begin
            strap_q <= strap_d;
            valid_q <= valid_d;
        end
    end

    assign strapLatched = strap_q;
    assign strapValid = valid_q;

endmodule : strap_capture

// File: hdl/event_flags.sv
// Sticky event flags that clear when software reads them.
// Assumes event inputs are one-cycle pulses or levels on the clock.
module event_flags #(
    parameter int N = 8 // Number of event flags
)
(
    input wire logic clk, // Device clock
    input wire logic rst, // Async reset, active high
    input wire logic [N-1:0] eventIn, // Event pulses
    input wire logic clearAll, // Read of flags taken
    output logic [N-1:0] flags // Sticky flags
);
    if (N < 1 || N > 8)
    begin : g_bad_width
        $error("event_flags: N must be 1..8");
    end

    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_flag
            // A new event in the clearing cycle survives the read
            assign flag_d[i] = eventIn[i] | (flag_q[i] & ~clearAll);
        end
    endgenerate

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flags = flag_q;

endmodule : event_flags

// File: hdl/phy_mode_strap_interrupt_regs.sv
// Vendor management registers: strap overrides, strap status,
// expanded control and the interrupt control/status register.
// Assumes the management-frame engine delivers one access per request
// and waits for the read answer one cycle later.
module phy_mode_strap_interrupt_regs
(
    input wire logic clk, // Device clock, 25 MHz
    input wire logic rst, // Async reset, active high
    input wire phy_regs_pkg::mgmt_req_t mgmtReq, // Register access request
    output phy_regs_pkg::mgmt_rsp_t mgmtRsp, // Read answer
    input wire phy_regs_pkg::strap_t strapPins, // Strap pin levels
    input wire logic [phy_regs_pkg::NUM_EVENTS-1:0] eventIn, // Event pulses
    output phy_regs_pkg::mode_t modes, // Operating mode controls
    output logic [phy_regs_pkg::STAT_ADDR_W-1:0] mgmtAddress, // Own bus address
    output logic intOut // Interrupt, active high
);
    import phy_regs_pkg::*;

    strap_t strapLatched;
    logic strapValid;
    logic [NUM_EVENTS-1:0] flags;
    logic readFlags;

    strap_capture u_strap (
        .clk(clk),
        .rst(rst),
        .strapPins(strapPins),
        .strapLatched(strapLatched),
        .strapValid(strapValid)
    );

    // Flags clear on any taken read of the interrupt register
    assign readFlags = mgmtReq.rd && (mgmtReq.addr == OFF_INT_CTRL_STATUS);

    event_flags #(
        .N(NUM_EVENTS)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .eventIn(eventIn),
        .clearAll(readFlags),
        .flags(flags)
    );

    // Control registers
    logic [DATA_W-1:0] ovr_q;
    logic [DATA_W-1:0] ovr_d;
    logic [DATA_W-1:0] exp_q;
    logic [DATA_W-1:0] exp_d;
    logic [NUM_EVENTS-1:0] intEn_q;
    logic [NUM_EVENTS-1:0] intEn_d;
    logic pmeLoaded_q;
    logic pmeLoaded_d;

    always_comb
    begin
        ovr_d = ovr_q;
        exp_d = exp_q;
        intEn_d = intEn_q;
        pmeLoaded_d = pmeLoaded_q;
        // Wake enable takes its strap once, unless software got there first
        if (strapValid && !pmeLoaded_q)
        begin
            ovr_d[OVR_PME_BIT] = strapLatched.pme;
            pmeLoaded_d = 1'b1;
        end
        if (mgmtReq.wr)
        begin
            if (mgmtReq.addr == OFF_STRAP_OVERRIDE)
            begin
                // Read-only bit keeps zero through the mask
                ovr_d = mgmtReq.wdata & OVR_WRITE_MASK;
                pmeLoaded_d = 1'b1;
            end
            else if (mgmtReq.addr == OFF_EXPANDED_CTRL)
            begin
                exp_d = mgmtReq.wdata;
            end
            else if (mgmtReq.addr == OFF_INT_CTRL_STATUS)
            begin
                // Low byte is flags and ignores writes
                intEn_d = mgmtReq.wdata[INT_EN_LSB +: NUM_EVENTS];
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ovr_q <= OVR_RESET;
            exp_q <= EXP_RESET;
            intEn_q <= INT_EN_RESET;
            pmeLoaded_q <= 1'b0;
        end
        else
        begin
            ovr_q <= ovr_d;
            exp_q <= exp_d;
            intEn_q <= intEn_d;
            pmeLoaded_q <= pmeLoaded_d;
        end
    end

    // Read path
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] intWord;
    mgmt_rsp_t rsp_q;
    mgmt_rsp_t rsp_d;

    always_comb
    begin
        statusWord = '0;
        statusWord[STAT_ADDR_LSB +: STAT_ADDR_W] = strapLatched.mgmtAddr;
        statusWord[STAT_RMII_BIT] = strapLatched.rmii;
        intWord = '0;
        intWord[INT_EN_LSB +: NUM_EVENTS] = intEn_q;
        intWord[INT_FLAG_LSB +: NUM_EVENTS] = flags;
    end

    always_comb
    begin
        rsp_d.valid = mgmtReq.rd;
        rsp_d.data = rsp_q.data;
        if (mgmtReq.rd)
        begin
            if (mgmtReq.addr == OFF_STRAP_OVERRIDE)
            begin
                rsp_d.data = ovr_q;
            end
            else if (mgmtReq.addr == OFF_STRAP_STATUS)
            begin
                rsp_d.data = statusWord;
            end
            else if (mgmtReq.addr == OFF_EXPANDED_CTRL)
            begin
                rsp_d.data = exp_q;
            end
            else if (mgmtReq.addr == OFF_INT_CTRL_STATUS)
            begin
                rsp_d.data = intWord;
            end
            else
            begin
                rsp_d.data = UNMAPPED_READ;
            end
        end
    end

    // Interrupt output, registered so it never glitches
    logic int_q;
    logic int_d;

    always_comb
    begin
        int_d = |(flags & intEn_q);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rsp_q <= '0;
            int_q <= 1'b0;
        end
        else
        begin
            rsp_q <= rsp_d;
            int_q <= int_d;
        end
    end

    assign mgmtRsp = rsp_q;
    assign intOut = int_q;

    // Repeater mode relies on the host also setting the interface override
    assign modes.repeaterBackToBackMode = ovr_q[OVR_REPEATER_BIT];
    assign modes.nandTreeMode = ovr_q[OVR_NAND_TREE_BIT];
    assign modes.rmiiMode = ovr_q[OVR_RMII_BIT];
    assign modes.pmeEnable = ovr_q[OVR_PME_BIT];
    assign modes.energyDetectPowerDownEn = ~exp_q[EXP_ENERGY_DETECT_OFF_BIT];
    assign mgmtAddress = strapLatched.mgmtAddr;

endmodule : phy_mode_strap_interrupt_regs

// File: tb/phy_regs_sva.sv
// Port checker for the vendor register bank.
// Assumes the bind below on every instance.
module phy_regs_sva
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire phy_regs_pkg::mgmt_req_t mgmtReq, // Request
    input wire phy_regs_pkg::mgmt_rsp_t mgmtRsp, // Answer
    input wire logic [phy_regs_pkg::NUM_EVENTS-1:0] eventIn, // Events
    input wire phy_regs_pkg::mode_t modes, // Modes
    input wire logic [phy_regs_pkg::STAT_ADDR_W-1:0] mgmtAddress, // Address
    input wire logic intOut // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    import phy_regs_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic wr16, wr18, rd17, rd1b;
    logic [DATA_W-1:0] d;
    assign d = mgmtReq.wdata;
    assign wr16 = mgmtReq.wr && mgmtReq.addr == OFF_STRAP_OVERRIDE;
    assign wr18 = mgmtReq.wr && mgmtReq.addr == OFF_EXPANDED_CTRL;
    assign rd17 = mgmtReq.rd && mgmtReq.addr == OFF_STRAP_STATUS;
    assign rd1b = mgmtReq.rd && mgmtReq.addr == OFF_INT_CTRL_STATUS;
    AST_RD_ANSWER: assert property (mgmtReq.rd |=> mgmtRsp.valid)
        else $error("read not answered");
    AST_NO_EXTRA: assert property (mgmtRsp.valid |-> $past(mgmtReq.rd))
        else $error("answer without read");
    AST_REPEATER: assert property (wr16 |=> modes.repeaterBackToBackMode == $past(d[6]))
        else $error("repeater mode wrong");
    AST_NAND: assert property (wr16 |=> modes.nandTreeMode == $past(d[5]))
        else $error("test chain mode wrong");
    AST_RMII: assert property (wr16 |=> modes.rmiiMode == $past(d[1]))
        else $error("interface mode wrong");
    AST_POWER_DOWN: assert property (wr18 |=> modes.energyDetectPowerDownEn != $past(d[11]))
        else $error("power-down control wrong");
    AST_ADDR_CODE: assert property (mgmtAddress inside {2'h0, 2'h3})
        else $error("unsupported address");
    AST_STAT_ADDR: assert property (rd17 |=> mgmtRsp.data[14:13] == mgmtAddress)
        else $error("status address field wrong");
    AST_FLAG_CLEAR: assert property (rd1b && eventIn == '0 |=> ##1 !intOut)
        else $error("interrupt held after read");
    cover property (rd1b ##1 mgmtRsp.data[7:0] != 8'h00);
    cover property (wr16 && d[6]);
    cover property ($rose(intOut));
endmodule : phy_regs_sva

bind phy_mode_strap_interrupt_regs phy_regs_sva sva (.clk(clk), .rst(rst),
    .mgmtReq(mgmtReq), .mgmtRsp(mgmtRsp), .eventIn(eventIn), .modes(modes),
    .mgmtAddress(mgmtAddress), .intOut(intOut));

// File: tb/mgmt_host.sv
// Management-bus host model with single-access tasks.
// Assumes one task runs at a time.
module mgmt_host
(
    input wire logic clk, // Clock
    output phy_regs_pkg::mgmt_req_t req, // Request
    input wire phy_regs_pkg::mgmt_rsp_t rsp // Answer
);
    timeunit 1ns;
    timeprecision 1ps;
    import phy_regs_pkg::*;
    initial req = '0;
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = d;
        if (a == OFF_STRAP_OVERRIDE && d[OVR_REPEATER_BIT])
            v[OVR_RMII_BIT] = 1'b1;
        @(posedge clk);
        req <= {1'b0, 1'b1, a, v};
        @(posedge clk);
        // Released lines show junk, not the old value
        req <= {1'b0, 1'b0, ~a, ~v};
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, DATA_W'($urandom)};
        @(posedge clk);
        req <= {1'b0, 1'b0, ~a, DATA_W'($urandom)};
        #1;
        d = rsp.valid ? rsp.data : 'x;
    endtask : rd
endmodule : mgmt_host

// File: tb/tb_phy_mode_strap_interrupt_regs.sv
// Self-checking bench: straps, register access, event flags.
// Assumes host model and checker compiled first.
module tb_phy_mode_strap_interrupt_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_regs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mgmt_req_t mgmtReq;
    mgmt_rsp_t mgmtRsp;
    strap_t strapPins = '0;
    strap_t st;
    logic [NUM_EVENTS-1:0] eventIn = '0;
    logic [NUM_EVENTS-1:0] en;
    mode_t modes;
    logic [STAT_ADDR_W-1:0] mgmtAddress;
    logic intOut;
    logic [DATA_W-1:0] got, w, e;
    int failures = 0;
    int total_checks = 0;
    phy_mode_strap_interrupt_regs uut (.clk(clk), .rst(rst), .mgmtReq(mgmtReq),
        .mgmtRsp(mgmtRsp), .strapPins(strapPins), .eventIn(eventIn), .modes(modes),
        .mgmtAddress(mgmtAddress), .intOut(intOut));
    mgmt_host host (.clk(clk), .req(mgmtReq), .rsp(mgmtRsp));
    initial forever #20 clk = ~clk;
    task automatic chk(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
        total_checks++;
        if (s !== x)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    function automatic logic [DATA_W-1:0] exp16(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = d & OVR_WRITE_MASK;
        v[OVR_RMII_BIT] = v[OVR_RMII_BIT] | d[OVR_REPEATER_BIT];
        return v;
    endfunction : exp16
    // Only addresses zero and three exist; other codes read as three
    function automatic logic [STAT_ADDR_W-1:0] expAddr(input logic [STAT_ADDR_W-1:0] a);
        return (a == STRAP_ADDR_ZERO) ? STRAP_ADDR_ZERO : STRAP_ADDR_THREE;
    endfunction : expAddr
    function automatic logic [DATA_W-1:0] exp17(input strap_t s);
        return {1'b0, expAddr(s.mgmtAddr), 11'h000, s.rmii, 1'b0};
    endfunction : exp17
    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Whole run is well under a thousand cycles
    initial
    begin
        #200000;
        failures++;
        final_report();
    end
    initial
    begin
        void'($urandom(11));
        for (int s = 0; s < 3; s++)
        begin
            st = {(s == 0) ? STRAP_ADDR_ZERO : ((s == 1) ? STRAP_ADDR_THREE : 2'h1),
                1'($urandom), 1'($urandom)};
            @(posedge clk);
            rst <= 1'b1;
            strapPins <= st;
            repeat (4) @(posedge clk);
            rst <= 1'b0;
            repeat (3) @(posedge clk);
            host.rd(OFF_STRAP_OVERRIDE, got);
            chk("override reset", got, OVR_RESET | {st.pme, 15'h0000});
            chk("modes reset", {11'h000, modes}, {11'h000, 3'b001, st.pme, 1'b0});
            chk("own address", {14'h0000, mgmtAddress}, {14'h0000, expAddr(st.mgmtAddr)});
            host.wr(OFF_STRAP_STATUS, 16'hffff);
            host.rd(OFF_STRAP_STATUS, got);
            chk("strap status", got, exp17(st));
            host.rd(OFF_EXPANDED_CTRL, got);
            chk("expanded reset", got, EXP_RESET);
            host.rd(OFF_INT_CTRL_STATUS, got);
            chk("int reset", got, 16'h0000);
            chk("int idle", {15'h0, intOut}, 16'h0000);
            host.rd(5'h10, got);
            chk("unmapped", got, UNMAPPED_READ);
            $display("Test reset strap %0d done", s);
        end
        for (int i = 0; i < 8; i++)
        begin
            w = i == 0 ? 16'hffff : DATA_W'($urandom);
            e = exp16(w);
            host.wr(OFF_STRAP_OVERRIDE, w);
            #1;
            chk("modes", {12'h000, modes[4:1]}, {12'h000, e[6:5], e[1], e[15]});
            host.rd(OFF_STRAP_OVERRIDE, got);
            chk("override", got, e);
            host.wr(OFF_EXPANDED_CTRL, w);
            #1;
            chk("power down", {15'h0, modes.energyDetectPowerDownEn}, {15'h0, ~w[11]});
            host.rd(OFF_EXPANDED_CTRL, got);
            chk("expanded", got, w);
        end
        $display("Test register access done");
        for (int k = 0; k < NUM_EVENTS; k++)
        begin
            en = NUM_EVENTS'($urandom);
            en[k] = k[0];
            host.wr(OFF_INT_CTRL_STATUS, {en, 8'hff});
            @(posedge clk);
            eventIn <= 8'h01 << k;
            @(posedge clk);
            eventIn <= 8'h00;
            @(posedge clk);
            #1;
            chk("int out", {15'h0, intOut}, {15'h0, en[k]});
            host.rd(OFF_INT_CTRL_STATUS, got);
            chk("flags", got, {en, 8'h01 << k});
            host.rd(OFF_INT_CTRL_STATUS, got);
            chk("flags cleared", got, {en, 8'h00});
            chk("int dropped", {15'h0, intOut}, 16'h0000);
        end
        // Event landing on the clearing read must survive it
        fork
            host.rd(OFF_INT_CTRL_STATUS, got);
            begin
                @(posedge clk);
                eventIn <= 8'h80;
                @(posedge clk);
                eventIn <= 8'h00;
            end
        join
        chk("flags before", got, {en, 8'h00});
        host.rd(OFF_INT_CTRL_STATUS, got);
        chk("flag kept", got, {en, 8'h80});
        host.rd(OFF_INT_CTRL_STATUS, got);
        chk("flag gone", got, {en, 8'h00});
        $display("Test events done");
        final_report();
    end
endmodule : tb_phy_mode_strap_interrupt_regs
